// File: trace_pkg.sv
// Trace capture constants, line layout and event carriers
package trace_pkg;
// ---------------------------------------------------------------
// ---------------------------------------------------------------

localparam int LINES = 64;
localparam int PTR_W = 6;
localparam int CNT_W = 7;
localparam logic [CNT_W-1:0] CNT_FULL = 7'h40;
localparam logic [CNT_W-1:0] CNT_RESET = 7'h00;

// ---------------------------------------------------------------
// Register map
// ---------------------------------------------------------------
localparam logic [31:0] CTRL_OFS = 32'h00000000;
localparam logic [31:0] COUNT_OFS = 32'h00000004;
localparam logic [31:0] WINDOW_OFS = 32'h00000008;
localparam int CTRL_EN_BIT = 0;
localparam int CTRL_MODE_LSB = 1;
localparam logic [1:0] RESP_OKAY = 2'h0;
localparam logic [1:0] RESP_DECERR = 2'h3;

// ---------------------------------------------------------------
// Field 2 layout
// ---------------------------------------------------------------
localparam int F2_SIZE_BIT = 3;
localparam int F2_DIR_BIT = 2;
localparam logic [3:0] F2_ZERO = 4'h0;
localparam logic [7:0] BYTE_ZERO = 8'h00;

typedef enum logic [1:0] {
	change_of_flow,
	loop_filter_mode,
	detail_mode,
	pure_program_counter_mode
} trace_mode_t;

typedef struct packed {
	logic [3:0] field2;
	logic [7:0] field1;
	logic [7:0] field0;
} trace_line_t;

typedef struct packed {
	logic valid;
	logic source_dest_flag;
	logic vector_flag;
	logic [17:0] pc;
} flow_event_t;

typedef struct packed {
	logic valid;
	logic [17:0] pc;
} opcode_event_t;

typedef struct packed {
	logic valid;
	logic free_cycle;
	logic opcode_fetch;
	logic byte_access;
	logic read;
	logic [17:0] addr;
	logic [15:0] data;
} bus_cycle_t;

endpackage : trace_pkg

// File: cpu_trace_buffer_capture.sv
// Trace capture core with circular line store and register slave
//
// Added by the designer: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
module cpu_trace_buffer_capture (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Cpu events
	input trace_pkg::flow_event_t flow_event,
	input trace_pkg::opcode_event_t opcode_event,
	input trace_pkg::bus_cycle_t bus_cycle,
	// Write address
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] awaddr,
	input wire logic [2:0] awprot,
	// Write data
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// Write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// Read address
	input wire logic arvalid,
	output logic arready,
	input wire logic [31:0] araddr,
	input wire logic [2:0] arprot,
	// Read data
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp
);
	import trace_pkg::*;

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef struct packed {
		trace_line_t [LINES-1:0] ram;
		logic [PTR_W-1:0] wr_ptr;
		logic [CNT_W-1:0] trace_line_counter;
		logic [PTR_W-1:0] rd_ptr;
		logic rd_phase;
		logic [17:0] background;
		logic trace_source_enable;
		trace_mode_t trace_mode_select;
		logic aw_got;
		logic [31:0] aw_addr;
		logic w_got;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic rd_is_high;
	} state_t;

	state_t st;
	state_t next_st;
	trace_line_t line_a;
	trace_line_t line_b;
	trace_line_t rd_line;
	logic store_a;
	logic store_b;
	logic [PTR_W-1:0] oldest;
	logic [PTR_W-1:0] ptr_b;
	logic [CNT_W-1:0] cnt_step;
	logic [CNT_W:0] cnt_sum;

	// ---------------------------------------------------------------
	// Line builders
	// ---------------------------------------------------------------
	// Vector implies destination even if the core forgets to flag it
	function automatic trace_line_t flow_line(input flow_event_t ev);
		trace_line_t l;
		l.field2 = {ev.source_dest_flag | ev.vector_flag, ev.vector_flag, ev.pc[17:16]};
		l.field1 = ev.pc[15:8];
		l.field0 = ev.pc[7:0];
		return l;
	endfunction : flow_line

	function automatic trace_line_t pc_line(input logic [17:0] pc);
		trace_line_t l;
		l.field2 = {2'b00, pc[17:16]};
		l.field1 = pc[15:8];
		l.field0 = pc[7:0];
		return l;
	endfunction : pc_line

	function automatic trace_line_t addr_line(input bus_cycle_t bc);
		trace_line_t l;
		l.field2 = {bc.byte_access, bc.read, bc.addr[17:16]};
		l.field1 = bc.addr[15:8];
		l.field0 = bc.addr[7:0];
		return l;
	endfunction : addr_line

	// Core supplies the byte of a byte access on data[7:0]
	function automatic trace_line_t data_line(input bus_cycle_t bc);
		trace_line_t l;
		l.field2 = F2_ZERO;
		if (bc.byte_access) begin
			l.field1 = BYTE_ZERO;
			l.field0 = bc.data[7:0];
		end else begin
			l.field1 = bc.data[15:8];
			l.field0 = bc.data[7:0];
		end
		return l;
	endfunction : data_line

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		next_st = st;
		line_a = '0;
		line_b = '0;
		store_a = 1'b0;
		store_b = 1'b0;
		ptr_b = '0;
		cnt_step = '0;
		cnt_sum = '0;
		oldest = (st.trace_line_counter == CNT_FULL) ? st.wr_ptr : '0;
		rd_line = st.ram[st.rd_ptr];

		// Write response retires first so a new write can be taken
		if (st.bvalid && bready) begin
			next_st.bvalid = 1'b0;
		end
		if (awvalid && st.awready) begin
			next_st.aw_got = 1'b1;
			next_st.aw_addr = awaddr;
		end
		if (wvalid && st.wready) begin
			next_st.w_got = 1'b1;
			next_st.w_data = wdata;
			next_st.w_strb = wstrb;
		end
		if (next_st.aw_got && next_st.w_got && !next_st.bvalid) begin
			next_st.aw_got = 1'b0;
			next_st.w_got = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = RESP_OKAY;
			unique case (next_st.aw_addr)
				CTRL_OFS: begin
					if (next_st.w_strb[0]) begin
						next_st.trace_source_enable = next_st.w_data[CTRL_EN_BIT];
						next_st.trace_mode_select =
							trace_mode_t'(next_st.w_data[CTRL_MODE_LSB +: 2]);
					end
				end
				COUNT_OFS: begin
					// Any write empties the store
					next_st.trace_line_counter = CNT_RESET;
					next_st.wr_ptr = '0;
					next_st.rd_ptr = '0;
					next_st.rd_phase = 1'b0;
				end
				WINDOW_OFS: begin
					// Restarts an interrupted readout from the oldest line
					next_st.rd_ptr = oldest;
					next_st.rd_phase = 1'b0;
				end
				default: begin
					next_st.bresp = RESP_DECERR;
				end
			endcase
		end
		next_st.awready = !next_st.aw_got && !next_st.bvalid;
		next_st.wready = !next_st.w_got && !next_st.bvalid;

		// Read channel
		if (st.rvalid && rready) begin
			next_st.rvalid = 1'b0;
		end
		if (arvalid && st.arready) begin
			next_st.rvalid = 1'b1;
			next_st.rresp = RESP_OKAY;
			next_st.rdata = '0;
			next_st.rd_is_high = 1'b0;
			unique case (araddr)
				CTRL_OFS: begin
					next_st.rdata[CTRL_EN_BIT] = st.trace_source_enable;
					next_st.rdata[CTRL_MODE_LSB +: 2] = st.trace_mode_select;
				end
				COUNT_OFS: begin
					next_st.rdata[CNT_W-1:0] = st.trace_line_counter;
				end
				WINDOW_OFS: begin
					// Reads as zero while tracing is not enabled
					if (st.trace_source_enable) begin
						if (!next_st.rd_phase) begin
							next_st.rdata[15:0] = {rd_line.field1, rd_line.field0};
							next_st.rd_phase = 1'b1;
						end else begin
							next_st.rdata[3:0] = rd_line.field2;
							next_st.rd_is_high = 1'b1;
							next_st.rd_phase = 1'b0;
							next_st.rd_ptr = next_st.rd_ptr + 1'b1;
						end
					end
				end
				default: begin
					next_st.rresp = RESP_DECERR;
				end
			endcase
		end
		next_st.arready = !next_st.rvalid;

		// Capture; the core qualifies flow events itself
		if (st.trace_source_enable) begin
			unique case (st.trace_mode_select)
				change_of_flow: begin
					if (flow_event.valid) begin
						store_a = 1'b1;
						line_a = flow_line(flow_event);
					end
				end
				loop_filter_mode: begin
					if (flow_event.valid && (flow_event.source_dest_flag ||
						flow_event.vector_flag || flow_event.pc != st.background)) begin
						store_a = 1'b1;
						line_a = flow_line(flow_event);
					end
				end
				detail_mode: begin
					if (bus_cycle.valid && !bus_cycle.free_cycle &&
						!bus_cycle.opcode_fetch) begin
						store_a = 1'b1;
						store_b = 1'b1;
						line_a = addr_line(bus_cycle);
						line_b = data_line(bus_cycle);
					end
				end
				pure_program_counter_mode: begin
					if (opcode_event.valid) begin
						store_a = 1'b1;
						line_a = pc_line(opcode_event.pc);
					end
				end
			endcase
		end

		// Both lines of a detail entry land in the same edge
		ptr_b = next_st.wr_ptr + 1'b1;
		if (store_a) begin
			next_st.ram[next_st.wr_ptr] = line_a;
		end
		if (store_b) begin
			next_st.ram[ptr_b] = line_b;
		end
		cnt_step = {5'h00, store_b, store_a & !store_b} ;
		next_st.wr_ptr = next_st.wr_ptr + cnt_step[PTR_W-1:0];
		cnt_sum = {1'b0, next_st.trace_line_counter} + {1'b0, cnt_step};
		next_st.trace_line_counter = (cnt_sum > {1'b0, CNT_FULL}) ?
			CNT_FULL : cnt_sum[CNT_W-1:0];
		// Compare sees the new value from the next edge on only
		if (store_a && st.trace_mode_select == loop_filter_mode) begin
			next_st.background = flow_event.pc;
		end
	end

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	// Store keeps its lines across reset so a crash can be read out
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '0;
			st.ram <= st.ram;
		end else begin
			st <= next_st;
		end
	end

	assign awready = st.awready;
	assign wready = st.wready;
	assign bvalid = st.bvalid;
	assign bresp = st.bresp;
	assign arready = st.arready;
	assign rvalid = st.rvalid;
	assign rdata = st.rdata;
	assign rresp = st.rresp;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	logic no_bus_write;
	assign no_bus_write = !(st.aw_got || (awvalid && st.awready));

	loop_suppress_a: assert property (
		st.trace_source_enable && st.trace_mode_select == loop_filter_mode &&
		flow_event.valid && !flow_event.source_dest_flag && !flow_event.vector_flag &&
		flow_event.pc == st.background && no_bus_write
		|=> st.wr_ptr == $past(st.wr_ptr))
		else $error("loop filter stored a duplicate source");

	loop_dest_kept_a: assert property (
		st.trace_source_enable && st.trace_mode_select == loop_filter_mode &&
		flow_event.valid && flow_event.source_dest_flag && no_bus_write
		|=> st.wr_ptr == $past(st.wr_ptr) + 6'h01 && st.background == $past(flow_event.pc))
		else $error("loop filter dropped a destination");

	detail_two_a: assert property (
		st.trace_source_enable && st.trace_mode_select == detail_mode &&
		bus_cycle.valid && !bus_cycle.free_cycle && !bus_cycle.opcode_fetch && no_bus_write
		|=> st.wr_ptr == $past(st.wr_ptr) + 6'h02)
		else $error("detail entry did not take two lines");

	detail_skip_a: assert property (
		st.trace_source_enable && st.trace_mode_select == detail_mode &&
		(bus_cycle.free_cycle || bus_cycle.opcode_fetch) && no_bus_write
		|=> $stable(st.wr_ptr))
		else $error("detail traced a free or fetch cycle");

	pure_program_counter_mode_a: assert property (
		st.trace_source_enable && st.trace_mode_select == pure_program_counter_mode &&
		opcode_event.valid && no_bus_write
		|=> st.ram[$past(st.wr_ptr)] == {2'b00, $past(opcode_event.pc)})
		else $error("opcode address not stored");

	byte_data_a: assert property (
		st.trace_source_enable && st.trace_mode_select == detail_mode &&
		bus_cycle.valid && bus_cycle.byte_access && !bus_cycle.free_cycle &&
		!bus_cycle.opcode_fetch && no_bus_write
		|=> st.ram[$past(st.wr_ptr) + 6'h01] == {12'h000, $past(bus_cycle.data[7:0])})
		else $error("byte data line malformed");

	addr_info_a: assert property (
		st.trace_source_enable && st.trace_mode_select == detail_mode &&
		bus_cycle.valid && !bus_cycle.free_cycle && !bus_cycle.opcode_fetch && no_bus_write
		|=> st.ram[$past(st.wr_ptr)].field2 ==
			{$past(bus_cycle.byte_access), $past(bus_cycle.read), $past(bus_cycle.addr[17:16])})
		else $error("address line info bits wrong");

	vector_dest_a: assert property (
		st.trace_source_enable && st.trace_mode_select == change_of_flow &&
		flow_event.valid && flow_event.vector_flag && no_bus_write
		|=> st.ram[$past(st.wr_ptr)].field2[3:2] == 2'b11)
		else $error("vector without destination flag");

	count_bound_a: assert property (
		st.trace_line_counter <= CNT_FULL)
		else $error("line counter beyond store depth");

	high_word_a: assert property (
		st.rvalid && st.rd_is_high |-> st.rdata[31:4] == 28'h0000000)
		else $error("field 2 readout not zero extended");

	word_data_a: assert property (
		st.trace_source_enable && st.trace_mode_select == detail_mode &&
		bus_cycle.valid && !bus_cycle.byte_access && !bus_cycle.free_cycle &&
		!bus_cycle.opcode_fetch && no_bus_write
		|=> st.ram[$past(st.wr_ptr) + 6'h01] == {4'h0, $past(bus_cycle.data)})
		else $error("word data line malformed");

	flow_line_a: assert property (
		st.trace_source_enable && st.trace_mode_select == change_of_flow &&
		flow_event.valid && !flow_event.vector_flag && no_bus_write
		|=> st.ram[$past(st.wr_ptr)] ==
			{$past(flow_event.source_dest_flag), 1'b0, $past(flow_event.pc)})
		else $error("flow line layout wrong");

	count_step_a: assert property (
		st.trace_source_enable && st.trace_mode_select == pure_program_counter_mode &&
		opcode_event.valid && st.trace_line_counter != CNT_FULL && no_bus_write
		|=> st.trace_line_counter == $past(st.trace_line_counter) + 7'h01)
		else $error("line counter missed a store");

endmodule : cpu_trace_buffer_capture

// File: cpu_core_model.sv
// Behavioural cpu core that reports flow, opcode and bus events
`timescale 1ns/1ps
module cpu_core_model (
	// Clock
	input wire logic aclk,
	// Events toward the trace core
	output trace_pkg::flow_event_t flow_event,
	output trace_pkg::opcode_event_t opcode_event,
	output trace_pkg::bus_cycle_t bus_cycle
);
	import trace_pkg::*;

	initial begin
		flow_event = '0;
		opcode_event = '0;
		bus_cycle = '0;
	end

	// Released payloads are inverted so a stale value never reads as fresh
	// The core classifies flow changes itself before reporting one
	task automatic flow(input logic sd, input logic vec, input logic [17:0] pc);
		flow_event <= {1'b1, sd, vec, pc};
		opcode_event <= {1'b0, ~opcode_event[17:0]};
		bus_cycle <= {1'b0, ~bus_cycle[37:0]};
		@(posedge aclk);
	endtask : flow

	task automatic op(input logic [17:0] pc);
		opcode_event <= {1'b1, pc};
		flow_event <= {1'b0, ~flow_event[19:0]};
		bus_cycle <= {1'b0, ~bus_cycle[37:0]};
		@(posedge aclk);
	endtask : op

	task automatic bus(input logic [4:0] kind, input logic [17:0] a, input logic [15:0] d);
		bus_cycle <= {kind, a, d};
		flow_event <= {1'b0, ~flow_event[19:0]};
		opcode_event <= {1'b0, ~opcode_event[17:0]};
		@(posedge aclk);
	endtask : bus

	task automatic idle();
		flow_event <= {1'b0, ~flow_event[19:0]};
		opcode_event <= {1'b0, ~opcode_event[17:0]};
		bus_cycle <= {1'b0, ~bus_cycle[37:0]};
	endtask : idle
endmodule : cpu_core_model

// File: tb.sv
// Self-checking bench for the trace capture core
`timescale 1ns/1ps
module tb;
	import trace_pkg::*;
	// ----------------
	// Signals
	// ----------------
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic arvalid = 1'b0;
	logic [31:0] awaddr = 32'h0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] araddr = 32'h0;
	logic [3:0] wstrb = 4'hf;
	logic [31:0] rdata;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	flow_event_t flow_event;
	opcode_event_t opcode_event;
	bus_cycle_t bus_cycle;
	int miscompares = 0;
	int total_checks = 0;
	logic [19:0] exp_q[$];

	always #5 aclk = ~aclk;

	cpu_core_model core (.aclk(aclk), .flow_event(flow_event), .opcode_event(opcode_event),
		.bus_cycle(bus_cycle));
	cpu_trace_buffer_capture dut (.aclk(aclk), .aresetn(aresetn), .flow_event(flow_event),
		.opcode_event(opcode_event), .bus_cycle(bus_cycle), .awvalid(awvalid),
		.awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready),
		.wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(1'b1), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
		.rvalid(rvalid), .rready(1'b1), .rdata(rdata), .rresp(rresp));

	// ----------------
	// Bus and check tasks
	// ----------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	// Both ready inputs are held high, so every answer is taken at once
	task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
		int n;
		n = 0;
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= d;
		do begin
			@(posedge aclk);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && n < 50);
		chk({31'h0, bvalid}, 32'h1, "bvalid");
		chk({30'h0, bresp}, {30'h0, r}, "bresp");
	endtask : wr

	task automatic rd(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
		int n;
		n = 0;
		arvalid <= 1'b1;
		araddr <= a;
		do begin
			@(posedge aclk);
			n++;
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && n < 50);
		chk({31'h0, rvalid}, 32'h1, "rvalid");
		chk(rdata, d, "rdata");
		chk({30'h0, rresp}, {30'h0, r}, "rresp");
	endtask : rd

	task automatic setup(input trace_mode_t m);
		wr(COUNT_OFS, 32'h0, RESP_OKAY);
		wr(CTRL_OFS, {29'h0, m, 1'b1}, RESP_OKAY);
		exp_q.delete();
	endtask : setup

	// Rewinds the readout, then reads every expected line oldest first
	task automatic drain();
		logic [19:0] ln;
		rd(COUNT_OFS, 32'(exp_q.size()), RESP_OKAY);
		wr(WINDOW_OFS, 32'h0, RESP_OKAY);
		foreach (exp_q[i]) begin
			ln = exp_q[i];
			rd(WINDOW_OFS, {16'h0, ln[15:0]}, RESP_OKAY);
			rd(WINDOW_OFS, {28'h0, ln[19:16]}, RESP_OKAY);
		end
	endtask : drain

	task automatic fl(input logic sd, input logic vec, input logic [17:0] pc, input logic keep);
		core.flow(sd, vec, pc);
		if (keep) exp_q.push_back({sd | vec, vec, pc});
	endtask : fl

	task automatic op(input logic [17:0] pc, input logic keep);
		core.op(pc);
		if (keep) exp_q.push_back({2'b00, pc});
	endtask : op

	// kind is {free, fetch, byte, read}
	task automatic bc(input logic [3:0] k, input logic [17:0] a, input logic [15:0] d,
		input logic keep);
		core.bus({1'b1, k}, a, d);
		if (keep && k[3:2] == 2'b00) begin
			exp_q.push_back({k[1:0], a});
			exp_q.push_back(k[1] ? {12'h0, d[7:0]} : {4'h0, d});
		end
	endtask : bc

	task automatic give_verdict();
		if (miscompares == 0 && total_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : give_verdict

	// ----------------
	// Tests
	// ----------------
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rd(CTRL_OFS, 32'h0, RESP_OKAY);
		rd(32'hc, 32'h0, RESP_DECERR);
		wr(32'h10, 32'h1, RESP_DECERR);
		setup(change_of_flow);
		fl(1'b0, 1'b0, 18'h21234, 1'b1);
		fl(1'b1, 1'b0, 18'h1abcd, 1'b1);
		fl(1'b0, 1'b1, 18'h0fff2, 1'b1);
		op(18'h00100, 1'b0);
		bc(4'h1, 18'h00200, 16'h1234, 1'b0);
		core.idle();
		drain();
		setup(loop_filter_mode);
		fl(1'b0, 1'b0, 18'h10010, 1'b1);
		fl(1'b0, 1'b0, 18'h10010, 1'b0);
		fl(1'b0, 1'b0, 18'h10010, 1'b0);
		fl(1'b1, 1'b0, 18'h10020, 1'b1);
		fl(1'b1, 1'b0, 18'h10020, 1'b1);
		fl(1'b0, 1'b0, 18'h10010, 1'b1);
		fl(1'b0, 1'b1, 18'h0fff0, 1'b1);
		fl(1'b0, 1'b1, 18'h0fff0, 1'b1);
		core.idle();
		drain();
		setup(detail_mode);
		rd(CTRL_OFS, 32'h5, RESP_OKAY);
		bc(4'h9, 18'h01111, 16'h1111, 1'b1);
		bc(4'h5, 18'h02222, 16'h2222, 1'b1);
		bc(4'h0, 18'h30456, 16'hbeef, 1'b1);
		bc(4'h3, 18'h10011, 16'h77a5, 1'b1);
		fl(1'b1, 1'b0, 18'h00300, 1'b0);
		op(18'h00400, 1'b0);
		bc(4'h1, 18'h2fffe, 16'h0102, 1'b1);
		core.idle();
		drain();
		setup(pure_program_counter_mode);
		op(18'h28001, 1'b1);
		op(18'h28001, 1'b1);
		op(18'h1fffe, 1'b1);
		fl(1'b1, 1'b1, 18'h00003, 1'b0);
		core.idle();
		drain();
		setup(detail_mode);
		for (int i = 0; i < 33; i++) bc(4'h0, 18'(i), 16'(i + 16'h0100), 1'b1);
		core.idle();
		exp_q = exp_q[2:$];
		drain();
		// Control byte lane masked: the write must leave mode and enable alone
		wstrb <= 4'he;
		wr(CTRL_OFS, 32'h0, RESP_OKAY);
		wstrb <= 4'hf;
		rd(CTRL_OFS, 32'h5, RESP_OKAY);
		wr(CTRL_OFS, {29'h0, change_of_flow, 1'b0}, RESP_OKAY);
		fl(1'b1, 1'b0, 18'h00500, 1'b0);
		core.idle();
		rd(COUNT_OFS, 32'h40, RESP_OKAY);
		rd(WINDOW_OFS, 32'h0, RESP_OKAY);
		rd(CTRL_OFS, 32'h0, RESP_OKAY);
		give_verdict();
	end

	// Watchdog well beyond the few hundred cycles the tests need
	initial begin
		#200000;
		miscompares++;
		give_verdict();
	end
endmodule : tb
